/* dv/sag_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Bus side: takes each physical address as a memory cycle and counts them.
module sag_bus_model (
  input wire logic ref_clk,
  input wire logic physValid_q,
  input wire logic [19:0] physAddr_q,
  output logic [19:0] lastAddr,
  output int nRefs
);
  initial begin
    lastAddr = 20'h0;
    nRefs = 0;
  end
  always @(posedge ref_clk) begin
    if (physValid_q) begin
      lastAddr <= physAddr_q;
      nRefs <= nRefs + 1;
    end
  end
endmodule // sag_bus_model
`default_nettype wire

/* dv/sag_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sag_core_monitor (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic refValid,
  input wire logic [2:0] refType,
  input wire logic physValid_q,
  input wire logic [19:0] physAddr_q,
  input wire logic [2:0] physType_q,
  input wire logic prefixValid,
  input wire logic instrDone,
  input wire logic overrideActive_q,
  input wire logic stepTrap_q,
  input wire logic intAccept_q,
  input wire logic maskableReq,
  input wire logic nonMaskableReq,
  input wire logic softwareReq,
  input wire logic pushPtr,
  input wire logic [15:0] savedPtr_q,
  input wire logic regWrite
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_pfx;
    prefixValid;
  endsequence
  sequence s_end;
    instrDone && !prefixValid;
  endsequence
  sequence s_fetch2;
    refValid && refType == 3'h0 && physValid_q && physType_q == 3'h0 && !$past(regWrite);
  endsequence
  a_ref_answer: assert property (
    refValid |=> physValid_q && physType_q == $past(refType)) else $error("no answer");
  a_ref_quiet: assert property (
    !refValid |=> !physValid_q && $stable(physAddr_q)) else $error("stray answer");
  a_fetch_step: assert property (
    s_fetch2 |=> physAddr_q == $past(physAddr_q) + 20'h1) else $error("fetch step");
  a_ovr_take: assert property (
    s_pfx |=> overrideActive_q) else $error("override not taken");
  a_ovr_end: assert property (
    s_end |=> !overrideActive_q) else $error("override kept");
  a_ovr_hold: assert property (
    !instrDone && !prefixValid |=> $stable(overrideActive_q)) else $error("override moved");
  a_step_cause: assert property (
    stepTrap_q |-> $past(instrDone)) else $error("stray step trap");
  a_int_cause: assert property (
    intAccept_q |-> $past(maskableReq || nonMaskableReq || softwareReq))
    else $error("stray interrupt");
  a_save_hold: assert property (
    !pushPtr |=> $stable(savedPtr_q)) else $error("saved pointer moved");
endmodule // sag_core_monitor
bind sag_core sag_core_monitor mon_u (.ref_clk(ref_clk), .arst_n(arst_n),
  .refValid(refValid), .refType(refType), .physValid_q(physValid_q),
  .physAddr_q(physAddr_q), .physType_q(physType_q), .prefixValid(prefixValid),
  .instrDone(instrDone), .overrideActive_q(overrideActive_q), .stepTrap_q(stepTrap_q),
  .intAccept_q(intAccept_q), .maskableReq(maskableReq), .nonMaskableReq(nonMaskableReq),
  .softwareReq(softwareReq), .pushPtr(pushPtr), .savedPtr_q(savedPtr_q), .regWrite(regWrite));
`default_nettype wire

/* dv/tb_segment_address_generator.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_segment_address_generator;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic refValid = 1'b0;
  logic [2:0] refType = 3'h0;
  logic [15:0] effAddr = 16'h0;
  logic [1:0] prefixSeg = 2'h0;
  logic [3:0] queueCount = 4'h0;
  logic strWord = 1'b0;
  logic aluWord = 1'b0;
  logic maskableReq = 1'b0;
  logic nmiReq = 1'b0;
  logic swReq = 1'b0;
  logic [15:0] opA = 16'h0;
  logic [15:0] opB = 16'h0;
  logic [15:0] opR = 16'h0;
  logic [5:0] ctl = 6'h0;
  wire logic [15:0] regRdData_q;
  wire logic [15:0] savedPtr_q;
  wire logic [19:0] physAddr_q;
  wire logic [19:0] lastAddr;
  wire logic physValid_q;
  wire logic intAccept_q;
  wire logic stepTrap_q;
  wire logic overrideActive_q;
  int nRefs;
  int nFail = 0;
  int nChecks = 0;
  int nExp = 0;
  int cyc = 0;
  sag_core dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData_q(regRdData_q), .refValid(refValid), .refType(refType),
    .effectiveAddress(effAddr), .prefixValid(ctl[0]), .prefixSeg(prefixSeg),
    .instrDone(ctl[1]), .queueCount(queueCount), .ptrLoad(1'b0), .ptrLoadValue(16'h0),
    .pushPtr(ctl[2]), .stackPush(ctl[3]), .stackPop(1'b0), .strStep(ctl[4]),
    .strWord(strWord), .aluValid(ctl[5]), .aluWord(aluWord), .aluOperandA(opA),
    .aluOperandB(opB), .aluResult(opR), .maskableReq(maskableReq),
    .nonMaskableReq(nmiReq), .softwareReq(swReq), .physValid_q(physValid_q),
    .physAddr_q(physAddr_q), .physType_q(), .savedPtr_q(savedPtr_q),
    .intAccept_q(intAccept_q), .stepTrap_q(stepTrap_q),
    .overrideActive_q(overrideActive_q));
  sag_bus_model bus_u (.ref_clk(ref_clk), .physValid_q(physValid_q),
    .physAddr_q(physAddr_q), .lastAddr(lastAddr), .nRefs(nRefs));
  always #2 ref_clk = ~ref_clk;
  task automatic test_done;
    if (nFail == 0 && nChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      nFail++;
      test_done;
    end
  end
  task automatic ck(input string n, input logic [19:0] e, input logic [19:0] s);
    nChecks++;
    if (s !== e) begin
      nFail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    ck($sformatf("reg%h", a), {4'h0, e}, {4'h0, regRdData_q});
  endtask
  task automatic rf(input logic [2:0] t, input logic [15:0] o, input logic [19:0] e);
    @(posedge ref_clk);
    refValid <= 1'b1;
    refType <= t;
    effAddr <= o;
    @(posedge ref_clk);
    refValid <= 1'b0;
    #1;
    nExp++;
    ck($sformatf("phys%h", t), e, physAddr_q);
  endtask
  // Pulse bits: 0 prefix, 1 done, 2 push pointer, 3 stack push, 4 string step, 5 alu.
  task automatic pl(input logic [5:0] m);
    @(posedge ref_clk);
    ctl <= m;
    @(posedge ref_clk);
    ctl <= 6'h0;
    #1;
  endtask
  task automatic t_reset;
    logic [15:0] rv [6] = '{16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, 16'hf000};
    for (int i = 0; i < 6; i++) rd(4'(i), rv[i]);
    rd(4'hd, 16'h0);
  endtask
  task automatic t_fetch;
    @(posedge ref_clk);
    refValid <= 1'b1;
    refType <= 3'h0;
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      #1;
      nExp++;
      ck("fetch", 20'hffff0 + 20'(i), physAddr_q);
    end
    refValid <= 1'b0;
    rd(4'hb, 16'hfff2);
    rd(4'hc, 16'h000f);
    wr(4'h4, 16'h1234);
    rd(4'h4, 16'h0003);
    queueCount <= 4'h2;
    pl(6'h04);
    rd(4'ha, 16'h0001);
    ck("savedPtr", 20'h00001, {4'h0, savedPtr_q});
  endtask
  task automatic t_segs;
    logic [19:0] ov [4] = '{20'h20010, 20'h00000, 20'h30010, 20'h10010};
    wr(4'h1, 16'h1000);
    wr(4'h2, 16'h2000);
    wr(4'h3, 16'h3000);
    wr(4'h6, 16'h0040);
    wr(4'h7, 16'h0100);
    wr(4'h8, 16'h0200);
    pl(6'h08);
    rd(4'h6, 16'h003e);
    rf(3'h1, 16'h0, 20'h3003e);
    rf(3'h2, 16'h0010, 20'h10010);
    rf(3'h5, 16'h0010, 20'h30010);
    rf(3'h3, 16'h0, 20'h10100);
    rf(3'h4, 16'h0, 20'h20200);
    for (int s = 0; s < 4; s++) begin
      prefixSeg <= 2'(s);
      pl(6'h01);
      ck("override", 20'h1, {19'h0, overrideActive_q});
      rf(3'h2, 16'h0010, ov[s]);
      rf(3'h5, 16'h0010, ov[s]);
      rf(3'h3, 16'h0, ov[s] + 20'hf0);
      rf(3'h4, 16'h0, 20'h20200);
      rf(3'h1, 16'h0, 20'h3003e);
      rf(3'h0, 16'h0, 20'hffff3 + 20'(s));
      pl(6'h02);
      ck("stepTrap", 20'h0, {19'h0, stepTrap_q});
      rf(3'h2, 16'h0010, 20'h10010);
    end
  endtask
  task automatic t_string;
    strWord <= 1'b1;
    pl(6'h10);
    rd(4'h7, 16'h0102);
    rd(4'h8, 16'h0202);
    wr(4'h5, 16'h0400);
    strWord <= 1'b0;
    pl(6'h10);
    rd(4'h7, 16'h0101);
    rd(4'h8, 16'h0201);
    rd(4'h5, 16'hf400);
  endtask
  task automatic t_flags;
    logic [15:0] tv [3][4] = '{'{16'h000f, 16'h0001, 16'h0010, 16'hf410},
      '{16'h0, 16'h0, 16'h0100, 16'hf444}, '{16'h0, 16'h0, 16'h0100, 16'hf400}};
    for (int i = 0; i < 3; i++) begin
      aluWord <= (i == 2);
      opA <= tv[i][0];
      opB <= tv[i][1];
      opR <= tv[i][2];
      pl(6'h20);
      rd(4'h5, tv[i][3]);
    end
  endtask
  task automatic t_int;
    maskableReq <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    ck("intAccept", 20'h0, {19'h0, intAccept_q});
    nmiReq <= 1'b1;
    @(posedge ref_clk);
    #1;
    ck("nmiAccept", 20'h1, {19'h0, intAccept_q});
    nmiReq <= 1'b0;
    swReq <= 1'b1;
    @(posedge ref_clk);
    #1;
    ck("swAccept", 20'h1, {19'h0, intAccept_q});
    swReq <= 1'b0;
    wr(4'h5, 16'h0600);
    @(posedge ref_clk);
    #1;
    ck("intAccept", 20'h1, {19'h0, intAccept_q});
    maskableReq <= 1'b0;
    wr(4'h5, 16'h0100);
    pl(6'h02);
    ck("stepTrap", 20'h1, {19'h0, stepTrap_q});
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset;
    t_fetch;
    t_segs;
    t_string;
    t_flags;
    t_int;
    ck("refs", 20'(nExp), 20'(nRefs));
    ck("lastAddr", 20'h10010, lastAddr);
    test_done;
  end
endmodule // tb_segment_address_generator
`default_nettype wire

/* verilog/sag_core.v */
// Functional notes
// - Reset: code base FFFF, other bases zero.
// - Reset clears instruction pointer to zero.
// - Instruction pointer 16 bits, not program-writable.
// - Pushed instruction pointer corrected for prefetch.
// - One 16-bit status word, resets to F000.
// - Half-carry set on low nibble carry/borrow.
// - Parity flag set on even one count.
// - Zero flag set when result is zero.
// - Direction flag set means indexes decrement.
// - Interrupt enable gates only maskable requests.
// - Single-step raises interrupt after each instruction.
// - Memory addresses are 20-bit physical.
// - Bases and offsets are unsigned 16-bit.
// - Segments up to 64K, overlap allowed.
// - Fetch uses code base and pointer, no override.
// - Stack uses stack base and top, no override.
// - Variables default data base, overridable.
// - String source: data base overridable, source index.
// - String destination: extra base, dest index only.
// - Frame-based operands default stack base, overridable.
// - String step moves indexes by byte or word.
// - Override prefix names base for operands until instruction end.
// - Address is base shifted four plus offset.
`timescale 1ns/1ps
`default_nettype none

`include "sag_defs.vh"

module sag_core (
  input wire ref_clk,
  input wire arst_n,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdData_q,
  input wire refValid,
  input wire [2:0] refType,
  input wire [15:0] effectiveAddress,
  input wire prefixValid,
  input wire [1:0] prefixSeg,
  input wire instrDone,
  input wire [3:0] queueCount,
  input wire ptrLoad,
  input wire [15:0] ptrLoadValue,
  input wire pushPtr,
  input wire stackPush,
  input wire stackPop,
  input wire strStep,
  input wire strWord,
  input wire aluValid,
  input wire aluWord,
  input wire [15:0] aluOperandA,
  input wire [15:0] aluOperandB,
  input wire [15:0] aluResult,
  input wire maskableReq,
  input wire nonMaskableReq,
  input wire softwareReq,
  output wire physValid_q,
  output wire [19:0] physAddr_q,
  output wire [2:0] physType_q,
  output reg [15:0] savedPtr_q,
  output reg intAccept_q,
  output reg stepTrap_q,
  output reg overrideActive_q
);

  reg [15:0] codeSeg_q;
  reg [15:0] dataSegmentBase_q;
  reg [15:0] extraSegmentBase_q;
  reg [15:0] stackSeg_q;
  reg [15:0] instructionPointer_q;
  reg [15:0] status_q;
  reg [15:0] stackTopOffset_q;
  reg [15:0] srcIndex_q;
  reg [15:0] destIndex_q;
  reg [15:0] frameBasePointer_q;
  reg [1:0] overrideSeg_q;
  reg [15:0] status_d;
  reg [15:0] selBase;
  reg [15:0] selOffset;
  wire [1:0] selIdx;
  wire [15:0] idxStep;
  wire [7:0] resLow;
  wire [15:0] halfMix;
  wire segWrite;
  wire addrHit;

  // Picks the segment for a reference; only three kinds listen to a prefix.
  function [1:0] segSelect;
    input [2:0] kind;
    input ovr;
    input [1:0] ovrSeg;
    begin
      case (kind)
        `SAG_REF_FETCH: segSelect = `SAG_SEG_CODE;
        `SAG_REF_STACK: segSelect = `SAG_SEG_STACK;
        `SAG_REF_VAR: segSelect = ovr ? ovrSeg : `SAG_SEG_DATA;
        `SAG_REF_STRSRC: segSelect = ovr ? ovrSeg : `SAG_SEG_DATA;
        `SAG_REF_STRDST: segSelect = `SAG_SEG_EXTRA;
        `SAG_REF_FRAME: segSelect = ovr ? ovrSeg : `SAG_SEG_STACK;
        default: segSelect = `SAG_SEG_DATA;
      endcase
    end
  endfunction

  function isMapped;
    input [3:0] a;
    begin
      isMapped = (a <= `SAG_OFF_PHYSHI);
    end
  endfunction

  assign selIdx = segSelect(refType, overrideActive_q, overrideSeg_q);
  assign segWrite = regWrite && (regAddr <= `SAG_OFF_STACK);
  assign addrHit = isMapped(regAddr);

  always @* begin
    case (selIdx)
      `SAG_SEG_EXTRA: begin
        selBase = extraSegmentBase_q;
      end
      `SAG_SEG_CODE: begin
        selBase = codeSeg_q;
      end
      `SAG_SEG_STACK: begin
        selBase = stackSeg_q;
      end
      default: begin
        selBase = dataSegmentBase_q;
      end
    endcase
  end

  // Offsets stay unsigned 16-bit; a segment wraps inside its 64K window.
  always @* begin
    case (refType)
      `SAG_REF_FETCH: begin
        selOffset = instructionPointer_q;
      end
      `SAG_REF_STACK: begin
        selOffset = stackTopOffset_q;
      end
      `SAG_REF_STRSRC: begin
        selOffset = srcIndex_q;
      end
      `SAG_REF_STRDST: begin
        selOffset = destIndex_q;
      end
      default: begin
        selOffset = effectiveAddress;
      end
    endcase
  end

  sag_phys_adder u_adder (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .addValid(refValid),
    .segBase(selBase),
    .offset(selOffset),
    .addType(refType),
    .physValid_q(physValid_q),
    .physAddr_q(physAddr_q),
    .physType_q(physType_q)
  );

  // Segment bases: software may load any value, overlap is legal.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      codeSeg_q <= `SAG_RST_CODE;
      dataSegmentBase_q <= `SAG_RST_SEG;
      extraSegmentBase_q <= `SAG_RST_SEG;
      stackSeg_q <= `SAG_RST_SEG;
    end else if (segWrite) begin
      case (regAddr)
        `SAG_OFF_CODE: begin
          codeSeg_q <= regWrData;
        end
        `SAG_OFF_DATA: begin
          dataSegmentBase_q <= regWrData;
        end
        `SAG_OFF_EXTRA: begin
          extraSegmentBase_q <= regWrData;
        end
        default: begin
          stackSeg_q <= regWrData;
        end
      endcase
    end
  end

  // The pointer is written only by the execution side, never by the port.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      instructionPointer_q <= `SAG_RST_IPTR;
    end else if (ptrLoad) begin
      instructionPointer_q <= ptrLoadValue;
    end else if (refValid && (refType == `SAG_REF_FETCH)) begin
      instructionPointer_q <= instructionPointer_q + 16'h0001;
    end
  end

  // Prefetched but unexecuted bytes are backed out of the saved copy.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      savedPtr_q <= `SAG_RST_IPTR;
    end else if (pushPtr) begin
      savedPtr_q <= instructionPointer_q - {12'h000, queueCount};
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stackTopOffset_q <= 16'h0000;
    end else if (regWrite && (regAddr == `SAG_OFF_STKTOP)) begin
      stackTopOffset_q <= regWrData;
    end else if (stackPush) begin
      stackTopOffset_q <= stackTopOffset_q - `SAG_STACK_STEP;
    end else if (stackPop) begin
      stackTopOffset_q <= stackTopOffset_q + `SAG_STACK_STEP;
    end
  end

  // Step size is one byte or one word; the sign follows the direction flag.
  assign idxStep = status_q[`SAG_BIT_DIR] ?
    (strWord ? 16'hfffe : 16'hffff) :
    (strWord ? 16'h0002 : 16'h0001);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      srcIndex_q <= 16'h0000;
      destIndex_q <= 16'h0000;
    end else begin
      if (regWrite && (regAddr == `SAG_OFF_SRCIDX)) begin
        srcIndex_q <= regWrData;
      end else if (strStep) begin
        srcIndex_q <= srcIndex_q + idxStep;
      end
      if (regWrite && (regAddr == `SAG_OFF_DSTIDX)) begin
        destIndex_q <= regWrData;
      end else if (strStep) begin
        destIndex_q <= destIndex_q + idxStep;
      end
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameBasePointer_q <= 16'h0000;
    end else if (regWrite && (regAddr == `SAG_OFF_FRAME)) begin
      frameBasePointer_q <= regWrData;
    end
  end

  // A new prefix wins over the end of the instruction before it.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overrideActive_q <= 1'b0;
      overrideSeg_q <= `SAG_SEG_DATA;
    end else if (prefixValid) begin
      overrideActive_q <= 1'b1;
      overrideSeg_q <= prefixSeg;
    end else if (instrDone) begin
      overrideActive_q <= 1'b0;
    end
  end

  assign resLow = aluResult[7:0];
  assign halfMix = aluOperandA ^ aluOperandB ^ aluResult;

  // Arithmetic results land after a same-cycle port write to the status word.
  always @* begin
    status_d = status_q;
    if (regWrite && (regAddr == `SAG_OFF_STATUS)) begin
      status_d = (regWrData & `SAG_STATUS_WMASK) | `SAG_STATUS_FIXED;
    end
    if (aluValid) begin
      status_d[`SAG_BIT_HALF] = halfMix[4];
      if (aluWord) begin
        status_d[`SAG_BIT_PARITY] = ~(^aluResult);
        status_d[`SAG_BIT_ZERO] = (aluResult == 16'h0000);
      end else begin
        status_d[`SAG_BIT_PARITY] = ~(^resLow);
        status_d[`SAG_BIT_ZERO] = (resLow == 8'h00);
      end
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= `SAG_RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      intAccept_q <= 1'b0;
      stepTrap_q <= 1'b0;
    end else begin
      intAccept_q <= (maskableReq && status_q[`SAG_BIT_INTEN]) ||
        nonMaskableReq || softwareReq;
      stepTrap_q <= instrDone && status_q[`SAG_BIT_STEP];
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_q <= 16'h0000;
    end else if (regRead && addrHit) begin
      case (regAddr)
        `SAG_OFF_CODE: begin
          regRdData_q <= codeSeg_q;
        end
        `SAG_OFF_DATA: begin
          regRdData_q <= dataSegmentBase_q;
        end
        `SAG_OFF_EXTRA: begin
          regRdData_q <= extraSegmentBase_q;
        end
        `SAG_OFF_STACK: begin
          regRdData_q <= stackSeg_q;
        end
        `SAG_OFF_IPTR: begin
          regRdData_q <= instructionPointer_q;
        end
        `SAG_OFF_STATUS: begin
          regRdData_q <= status_q;
        end
        `SAG_OFF_STKTOP: begin
          regRdData_q <= stackTopOffset_q;
        end
        `SAG_OFF_SRCIDX: begin
          regRdData_q <= srcIndex_q;
        end
        `SAG_OFF_DSTIDX: begin
          regRdData_q <= destIndex_q;
        end
        `SAG_OFF_FRAME: begin
          regRdData_q <= frameBasePointer_q;
        end
        `SAG_OFF_SAVEDIP: begin
          regRdData_q <= savedPtr_q;
        end
        `SAG_OFF_PHYSLO: begin
          regRdData_q <= physAddr_q[15:0];
        end
        default: begin
          regRdData_q <= {12'h000, physAddr_q[19:16]};
        end
      endcase
    end else begin
      regRdData_q <= 16'h0000;
    end
  end

endmodule // sag_core

`default_nettype wire

/* verilog/sag_defs.vh */
`ifndef SAG_DEFS_VH
`define SAG_DEFS_VH

// Register offsets on the plain register port (word index).
`define SAG_OFF_CODE 4'h0
`define SAG_OFF_DATA 4'h1
`define SAG_OFF_EXTRA 4'h2
`define SAG_OFF_STACK 4'h3
`define SAG_OFF_IPTR 4'h4
`define SAG_OFF_STATUS 4'h5
`define SAG_OFF_STKTOP 4'h6
`define SAG_OFF_SRCIDX 4'h7
`define SAG_OFF_DSTIDX 4'h8
`define SAG_OFF_FRAME 4'h9
`define SAG_OFF_SAVEDIP 4'ha
`define SAG_OFF_PHYSLO 4'hb
`define SAG_OFF_PHYSHI 4'hc

// Reset values.
`define SAG_RST_CODE 16'hffff
`define SAG_RST_SEG 16'h0000
`define SAG_RST_IPTR 16'h0000
`define SAG_RST_STATUS 16'hf000

// Status word field positions.
`define SAG_BIT_CARRY 0
`define SAG_BIT_PARITY 2
`define SAG_BIT_HALF 4
`define SAG_BIT_ZERO 6
`define SAG_BIT_SIGN 7
`define SAG_BIT_STEP 8
`define SAG_BIT_INTEN 9
`define SAG_BIT_DIR 10
`define SAG_BIT_OVF 11
`define SAG_STATUS_FIXED 16'hf000
`define SAG_STATUS_WMASK 16'h0fd5

// Segment indices.
`define SAG_SEG_EXTRA 2'h0
`define SAG_SEG_CODE 2'h1
`define SAG_SEG_STACK 2'h2
`define SAG_SEG_DATA 2'h3

// Memory reference types.
`define SAG_REF_FETCH 3'h0
`define SAG_REF_STACK 3'h1
`define SAG_REF_VAR 3'h2
`define SAG_REF_STRSRC 3'h3
`define SAG_REF_STRDST 3'h4
`define SAG_REF_FRAME 3'h5

// Address shaping.
`define SAG_SEG_SHIFT 4
`define SAG_STACK_STEP 16'h0002

`endif

/* verilog/sag_phys_adder.v */
`timescale 1ns/1ps
`default_nettype none

`include "sag_defs.vh"

// Dedicated physical address adder with a registered result.
module sag_phys_adder (
  input wire ref_clk,
  input wire arst_n,
  input wire addValid,
  input wire [15:0] segBase,
  input wire [15:0] offset,
  input wire [2:0] addType,
  output reg physValid_q,
  output reg [19:0] physAddr_q,
  output reg [2:0] physType_q
);

  wire [19:0] segShifted;
  wire [19:0] physSum;

  // Both halves are unsigned; the carry out of bit 19 is dropped.
  assign segShifted = {segBase, 4'h0};
  assign physSum = segShifted + {4'h0, offset};

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      physValid_q <= 1'b0;
      physAddr_q <= 20'h00000;
      physType_q <= 3'h0;
    end else begin
      physValid_q <= addValid;
      if (addValid) begin
        physAddr_q <= physSum;
        physType_q <= addType;
      end
    end
  end

endmodule // sag_phys_adder

`default_nettype wire
